// ### src/limit_pkg.sv
package limit_pkg;

   // ----------------------------------------
   // Register byte offsets
   // ----------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_OFFSET = 8'h04;
   localparam logic [7:0] OFS_SCALE = 8'h08;
   localparam logic [7:0] OFS_WARN_PCT = 8'h0C;
   localparam logic [7:0] OFS_MIN_TIME = 8'h10;
   localparam logic [7:0] OFS_FLAGS = 8'h14;
   localparam logic [7:0] OFS_LIMIT = 8'h18;
   localparam logic [7:0] OFS_WARN_LIMIT = 8'h1C;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
   localparam logic [7:0] OFS_TEMP_CFG = 8'h28;
   localparam logic [7:0] OFS_TEMP = 8'h2C;
   localparam logic [7:0] OFS_STEP0 = 8'h40;

   // ----------------------------------------
   // Field positions and scale factors
   // ----------------------------------------
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_NSTEPS_LSB = 4;
   localparam int CTRL_ACK_BIT = 8;
   localparam int STEP_OFS_LSB = 16;
   localparam int TEMP_GAIN_LSB = 16;
   localparam int SCALE_FRAC = 8;
   localparam int GAIN_FRAC = 8;
   localparam int PCT_FULL = 100;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] OFFSET_RST = 32'h0000_012C;
   localparam logic [31:0] SCALE_RST = 32'h0000_0000;
   localparam logic [31:0] WARN_PCT_RST = 32'h0000_0050;
   localparam logic [31:0] TEMP_CFG_RST = 32'h0100_0000;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int MIN_TIME_NS = 1000000;
   localparam logic [31:0] MIN_TIME_CYC = 32'((MIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {LIM_STATIC, LIM_DYNAMIC, LIM_STEP} limit_mode_e;

   typedef struct packed {
      logic temp;
      logic alarm;
      logic over;
      logic warn;
   } event_s;

endpackage : limit_pkg

// ### src/residual_current_limit_monitor.sv
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Warning flag rises when sample exceeds the applicable warning limit.
// - Overcurrent flag rises when sample exceeds the applicable limit.
// - Alarm sets only after overcurrent persists longer than the minimum time.
// - Overcurrent flag clears by itself once sample falls back.
// - Warning flag clears by itself once sample falls back.
// - Alarm stays latched until software acknowledges it.
// - Step offsets may be non-monotonic across reference steps.
// - Temperature derives from the average of accumulated resistance samples.
// - Warning limit is limit times warning percentage.
// - Dynamic limit is reference times scale plus static offset.
// - Stepwise limit is offset plus highest exceeded step offset, of up to 10.
module residual_current_limit_monitor #(
   parameter int DATA_W = 16,
   parameter int STEPS = 10,
   parameter int AVG_LOG2 = 3,
   parameter logic [31:0] MIN_TIME_CYC = limit_pkg::MIN_TIME_CYC
) (
   input wire logic aclk, // Clock
   input wire logic aresetn, // Sync reset, low
   input wire logic [7:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Byte strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Response valid
   input wire logic s_axi_bready, // Response ready
   input wire logic [7:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read valid
   input wire logic s_axi_rready, // Read ready
   input wire logic sample_valid, // New current sample
   input wire logic [DATA_W-1:0] sample_current, // Residual current
   input wire logic [DATA_W-1:0] reference_value, // Reference measurement
   input wire logic res_valid, // New resistance sample
   input wire logic [DATA_W-1:0] res_value, // Resistance sample
   output logic warning, // Warning flag
   output logic overcurrent, // Overcurrent flag
   output logic alarm, // Latched alarm
   output logic irq, // Interrupt level
   output logic [DATA_W-1:0] temperature, // Derived temperature
   output logic temp_ready // Temperature updated
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic [31:0] ctrl_reg, offset_reg, scale_reg, pct_reg, min_time_reg, temp_cfg_reg;
   logic [31:0] step_reg [STEPS];
   logic [3:0] stat_reg, mask_reg;
   logic aw_got_reg, w_got_reg, ack_reg;
   logic [7:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic wr_exec, wr_ok;
   logic [31:0] rdata_next;
   logic [31:0] lim_next, step_off, lim_reg, warn_lim_reg;
   logic [DATA_W-1:0] cur_s1_reg;
   logic s1_valid_reg;
   logic [31:0] cnt_reg;
   limit_pkg::event_s ev, prev_reg;
   logic [DATA_W+AVG_LOG2-1:0] acc_reg, acc_sum;
   logic [AVG_LOG2-1:0] avg_cnt_reg;
   logic [DATA_W-1:0] avg;
   logic signed [DATA_W:0] delta;
   logic signed [DATA_W+16:0] prod;
   limit_pkg::limit_mode_e mode;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Byte-lane merge of a write
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
         if (s[b]) r[8*b +: 8] = d[8*b +: 8];
      return r;
   endfunction : merge

   // Mapped address check
   function automatic logic addr_ok(input logic [7:0] a);
      return (a <= limit_pkg::OFS_TEMP) ||
             (a >= limit_pkg::OFS_STEP0 && a < limit_pkg::OFS_STEP0 + 8'(4 * STEPS));
   endfunction : addr_ok

   // ----------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------
   assign wr_exec = aw_got_reg && w_got_reg;
   assign wr_ok = addr_ok(awaddr_reg);

   // Address and data capture, either order
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_got_reg <= 1'b0;
         w_got_reg <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         awaddr_reg <= 8'h00;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_got_reg <= 1'b1;
            s_axi_awready <= 1'b0;
            awaddr_reg <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_got_reg <= 1'b1;
            s_axi_wready <= 1'b0;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         if (wr_exec)
         begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
         end
         if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Write response, SLVERR when unmapped
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
      end
      else if (wr_exec)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // Configuration registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_reg <= limit_pkg::CTRL_RST;
         offset_reg <= limit_pkg::OFFSET_RST;
         scale_reg <= limit_pkg::SCALE_RST;
         pct_reg <= limit_pkg::WARN_PCT_RST;
         min_time_reg <= MIN_TIME_CYC;
         mask_reg <= 4'h0;
         temp_cfg_reg <= limit_pkg::TEMP_CFG_RST;
         for (int i = 0; i < STEPS; i++) step_reg[i] <= 32'h0000_0000;
      end
      else if (wr_exec)
      begin
         case (awaddr_reg)
            limit_pkg::OFS_CTRL: ctrl_reg <= merge(ctrl_reg, wdata_reg, wstrb_reg) & 32'h0000_00F3;
            limit_pkg::OFS_OFFSET: offset_reg <= merge(offset_reg, wdata_reg, wstrb_reg);
            limit_pkg::OFS_SCALE: scale_reg <= merge(scale_reg, wdata_reg, wstrb_reg);
            limit_pkg::OFS_WARN_PCT: pct_reg <= merge(pct_reg, wdata_reg, wstrb_reg) & 32'h0000_00FF;
            limit_pkg::OFS_MIN_TIME: min_time_reg <= merge(min_time_reg, wdata_reg, wstrb_reg);
            limit_pkg::OFS_IRQ_MASK: mask_reg <= wstrb_reg[0] ? wdata_reg[3:0] : mask_reg;
            limit_pkg::OFS_TEMP_CFG: temp_cfg_reg <= merge(temp_cfg_reg, wdata_reg, wstrb_reg);
            default:
               for (int i = 0; i < STEPS; i++)
                  if (awaddr_reg == limit_pkg::OFS_STEP0 + 8'(4 * i))
                     step_reg[i] <= merge(step_reg[i], wdata_reg, wstrb_reg);
         endcase
      end
   end

   // Acknowledge pulse, self-clearing
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ack_reg <= 1'b0;
      else
         ack_reg <= wr_exec && awaddr_reg == limit_pkg::OFS_CTRL && wstrb_reg[1] &&
                    wdata_reg[limit_pkg::CTRL_ACK_BIT];
   end

   // ----------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------
   // Read data selection
   always_comb
   begin
      rdata_next = 32'h0000_0000;
      case ({s_axi_araddr[7:2], 2'b00})
         limit_pkg::OFS_CTRL: rdata_next = ctrl_reg;
         limit_pkg::OFS_OFFSET: rdata_next = offset_reg;
         limit_pkg::OFS_SCALE: rdata_next = scale_reg;
         limit_pkg::OFS_WARN_PCT: rdata_next = pct_reg;
         limit_pkg::OFS_MIN_TIME: rdata_next = min_time_reg;
         limit_pkg::OFS_FLAGS: rdata_next = {29'h0, alarm, overcurrent, warning};
         limit_pkg::OFS_LIMIT: rdata_next = lim_reg;
         limit_pkg::OFS_WARN_LIMIT: rdata_next = warn_lim_reg;
         limit_pkg::OFS_IRQ_STAT: rdata_next = {28'h0, stat_reg};
         limit_pkg::OFS_IRQ_MASK: rdata_next = {28'h0, mask_reg};
         limit_pkg::OFS_TEMP_CFG: rdata_next = temp_cfg_reg;
         limit_pkg::OFS_TEMP: rdata_next = 32'(temperature);
         default:
            for (int i = 0; i < STEPS; i++)
               if ({s_axi_araddr[7:2], 2'b00} == limit_pkg::OFS_STEP0 + 8'(4 * i))
                  rdata_next = step_reg[i];
      endcase
   end

   // Read handshake, one cycle latency
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'b00;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rdata_next;
         s_axi_rresp <= addr_ok({s_axi_araddr[7:2], 2'b00}) ? 2'b00 : 2'b10;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ----------------------------------------
   // Limit calculation
   // ----------------------------------------
   assign mode = limit_pkg::limit_mode_e'(ctrl_reg[limit_pkg::CTRL_MODE_LSB +: 2]);

   // Mode-dependent limit from the reference
   always_comb
   begin
      step_off = 32'h0000_0000;
      for (int i = 0; i < STEPS; i++)
         if (4'(i) < ctrl_reg[limit_pkg::CTRL_NSTEPS_LSB +: 4] &&
             reference_value > step_reg[i][DATA_W-1:0])
            step_off = 32'(step_reg[i][limit_pkg::STEP_OFS_LSB +: 16]);
      case (mode)
         limit_pkg::LIM_DYNAMIC:
            lim_next = 32'((48'(reference_value) * 48'(scale_reg)) >> limit_pkg::SCALE_FRAC)
                       + offset_reg;
         limit_pkg::LIM_STEP: lim_next = offset_reg + step_off;
         default: lim_next = offset_reg;
      endcase
   end

   // Stage one: latch sample with its limit
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s1_valid_reg <= 1'b0;
         cur_s1_reg <= '0;
         lim_reg <= 32'h0000_0000;
         warn_lim_reg <= 32'h0000_0000;
      end
      else
      begin
         s1_valid_reg <= sample_valid;
         if (sample_valid)
         begin
            cur_s1_reg <= sample_current;
            lim_reg <= lim_next;
            warn_lim_reg <= 32'((40'(lim_next) * 40'(pct_reg[7:0])) / limit_pkg::PCT_FULL);
         end
      end
   end

   // ----------------------------------------
   // Flags
   // ----------------------------------------
   // Stage two: compare, flags follow the sample
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         warning <= 1'b0;
         overcurrent <= 1'b0;
      end
      else if (s1_valid_reg)
      begin
         warning <= 32'(cur_s1_reg) > warn_lim_reg;
         overcurrent <= 32'(cur_s1_reg) > lim_reg;
      end
   end

   // Exceedance duration, saturating
   always_ff @(posedge aclk)
   begin
      if (!aresetn || !overcurrent)
         cnt_reg <= 32'h0000_0000;
      else if (cnt_reg != 32'hFFFF_FFFF)
         cnt_reg <= cnt_reg + 32'h0000_0001;
   end

   // Latched alarm, set wins over acknowledge
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         alarm <= 1'b0;
      else if (overcurrent && cnt_reg >= min_time_reg)
         alarm <= 1'b1;
      else if (ack_reg)
         alarm <= 1'b0;
   end

   // ----------------------------------------
   // Temperature averaging
   // ----------------------------------------
   assign acc_sum = acc_reg + (DATA_W + AVG_LOG2)'(res_value);
   assign avg = acc_sum[DATA_W+AVG_LOG2-1:AVG_LOG2];
   assign delta = $signed({1'b0, avg}) - $signed({1'b0, temp_cfg_reg[DATA_W-1:0]});
   assign prod = delta * $signed(temp_cfg_reg[limit_pkg::TEMP_GAIN_LSB +: 16]);

   // Accumulate, average, convert
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         acc_reg <= '0;
         avg_cnt_reg <= '0;
         temperature <= '0;
         temp_ready <= 1'b0;
      end
      else
      begin
         temp_ready <= 1'b0;
         if (res_valid)
         begin
            avg_cnt_reg <= avg_cnt_reg + 1'b1;
            acc_reg <= acc_sum;
            if (&avg_cnt_reg)
            begin
               acc_reg <= '0;
               temperature <= prod[DATA_W+limit_pkg::GAIN_FRAC-1:limit_pkg::GAIN_FRAC];
               temp_ready <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------
   // Interrupts
   // ----------------------------------------
   assign ev = '{temp: temp_ready, alarm: alarm & ~prev_reg.alarm,
                 over: overcurrent & ~prev_reg.over, warn: warning & ~prev_reg.warn};

   // Sticky status, write one clears, event wins
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         prev_reg <= '0;
         stat_reg <= 4'h0;
         irq <= 1'b0;
      end
      else
      begin
         prev_reg <= '{temp: 1'b0, alarm: alarm, over: overcurrent, warn: warning};
         stat_reg <= (stat_reg & ~((wr_exec && awaddr_reg == limit_pkg::OFS_IRQ_STAT &&
                      wstrb_reg[0]) ? wdata_reg[3:0] : 4'h0)) | ev;
         irq <= |(stat_reg & mask_reg);
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_warn_set: assert property (s1_valid_reg && 32'(cur_s1_reg) > warn_lim_reg
      |=> warning)
      else $error("warning not set");
   chk_over_set: assert property (s1_valid_reg && 32'(cur_s1_reg) > lim_reg
      |=> overcurrent)
      else $error("overcurrent not set");
   chk_alarm_delay: assert property ($rose(alarm) |-> $past(overcurrent) &&
      $past(cnt_reg) >= $past(min_time_reg))
      else $error("alarm too early");
   chk_over_clear: assert property (s1_valid_reg && 32'(cur_s1_reg) <= lim_reg
      |=> !overcurrent)
      else $error("overcurrent not cleared");
   chk_warn_clear: assert property (s1_valid_reg && 32'(cur_s1_reg) <= warn_lim_reg
      |=> !warning)
      else $error("warning not cleared");
   chk_alarm_latch: assert property (alarm && !ack_reg |=> alarm)
      else $error("alarm dropped without ack");
   chk_temp_period: assert property (res_valid && &avg_cnt_reg
      |=> temp_ready ##1 !temp_ready)
      else $error("temperature not updated");
   chk_warn_calc: assert property (s1_valid_reg |-> warn_lim_reg ==
      32'((40'(lim_reg) * 40'($past(pct_reg[7:0]))) / limit_pkg::PCT_FULL))
      else $error("warning limit wrong");
   chk_static_limit: assert property (sample_valid && mode == limit_pkg::LIM_STATIC
      |=> lim_reg == $past(offset_reg))
      else $error("static limit wrong");
   chk_step_none: assert property (sample_valid && mode == limit_pkg::LIM_STEP &&
      ctrl_reg[7:4] == 4'h0 |=> lim_reg == $past(offset_reg))
      else $error("stepwise limit without steps wrong");

   cov_alarm: cover property ($rose(alarm));
   cov_ack: cover property (alarm ##1 !alarm);
   cov_step: cover property (s1_valid_reg && mode == limit_pkg::LIM_STEP && overcurrent);
   cov_irq: cover property ($rose(irq));

endmodule : residual_current_limit_monitor

`default_nettype wire

// ### verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   // ----------------------------------------
   // Signals and counters
   // ----------------------------------------
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, sample_valid, res_valid;
   logic warning, overcurrent, alarm, irq, temp_ready;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic [15:0] sample_current, reference_value, res_value, temperature;
   logic [15:0] thr[3] = '{16'h0064, 16'h00C8, 16'h012C};
   logic [15:0] ofs[3] = '{16'h0032, 16'h0014, 16'h0050};
   logic [15:0] refs[5] = '{16'h0032, 16'h0064, 16'h0096, 16'h00FA, 16'h015E};
   logic [31:0] lims[5] = '{32'h0000_012C, 32'h0000_012C, 32'h0000_015E, 32'h0000_0140,
      32'h0000_017C};
   int miscompares, checked;

   // Device under test with a short alarm lead time
   residual_current_limit_monitor #(.MIN_TIME_CYC(32'h0000_0005))
      residual_current_limit_monitor_inst (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .sample_valid(sample_valid), .sample_current(sample_current),
      .reference_value(reference_value), .res_valid(res_valid), .res_value(res_value),
      .warning(warning), .overcurrent(overcurrent), .alarm(alarm), .irq(irq),
      .temperature(temperature), .temp_ready(temp_ready)
   );

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : check_word

   task automatic check_bit(input string what, input logic exp, input logic got);
      checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask : check_bit

   // Address and data offered together, each released when taken
   // Loop body runs first, as the request only lands after this time step
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
      logic [1:0] r;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         r = (bvalid && bready) ? bresp : r;
         if (bvalid && bready) bready <= 1'b0;
      end
      while (awvalid || wvalid || bready);
      check_word("bresp", {30'h0, resp}, {30'h0, r});
   endtask : axi_write

   task automatic rd_check(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] resp,
      input string what);
      logic [31:0] d;
      logic [1:0] r;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         d = (rvalid && rready) ? rdata : d;
         r = (rvalid && rready) ? rresp : r;
         if (rvalid && rready) rready <= 1'b0;
      end
      while (arvalid || rready);
      check_word(what, exp, d);
      check_word("rresp", {30'h0, resp}, {30'h0, r});
   endtask : rd_check

   // One sample pulse, then wait until the flags have settled
   task automatic send_sample(input logic [15:0] cur, input logic [15:0] refv);
      sample_current <= cur;
      reference_value <= refv;
      sample_valid <= 1'b1;
      @(posedge aclk);
      sample_valid <= 1'b0;
      repeat (3) @(posedge aclk);
   endtask : send_sample

   task automatic check_flags(input logic w, input logic o, input logic a);
      check_bit("warning", w, warning);
      check_bit("overcurrent", o, overcurrent);
      check_bit("alarm", a, alarm);
   endtask : check_flags

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : report_and_stop

   // ----------------------------------------
   // Clock and watchdog
   // ----------------------------------------
   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   // Cuts a hang short well beyond the expected run
   initial
   begin
      repeat (20000) @(posedge aclk);
      miscompares++;
      report_and_stop();
   end

   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial
   begin
      int i, n;
      {aresetn, awvalid, wvalid, bready, arvalid, rready, sample_valid, res_valid} = '0;
      {awaddr, araddr, wdata, sample_current, reference_value, res_value} = '0;
      wstrb = 4'hF;
      miscompares = 0;
      checked = 0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      // Reset values, unmapped and read-only places
      rd_check(limit_pkg::OFS_CTRL, 32'h0000_0000, 2'b00, "ctrl");
      rd_check(limit_pkg::OFS_OFFSET, 32'h0000_012C, 2'b00, "offset");
      rd_check(limit_pkg::OFS_WARN_PCT, 32'h0000_0050, 2'b00, "warn pct");
      rd_check(limit_pkg::OFS_TEMP_CFG, 32'h0100_0000, 2'b00, "temp cfg");
      rd_check(8'h30, 32'h0000_0000, 2'b10, "unmapped");
      axi_write(8'h34, 32'h0000_0001, 2'b10);
      axi_write(limit_pkg::OFS_FLAGS, 32'h0000_0007, 2'b00);
      rd_check(limit_pkg::OFS_FLAGS, 32'h0000_0000, 2'b00, "flags");
      axi_write(limit_pkg::OFS_MIN_TIME, 32'h0000_0005, 2'b00);
      axi_write(limit_pkg::OFS_IRQ_MASK, 32'h0000_0002, 2'b00);
      // Static limit 300, warning limit 240, equal is not exceeded
      send_sample(16'h00F0, 16'h0000);
      check_flags(1'b0, 1'b0, 1'b0);
      send_sample(16'h00F1, 16'h0000);
      check_flags(1'b1, 1'b0, 1'b0);
      send_sample(16'h012C, 16'h0000);
      check_flags(1'b1, 1'b0, 1'b0);
      send_sample(16'h012D, 16'h0000);
      check_flags(1'b1, 1'b1, 1'b0);
      // Brief violation raises no alarm
      send_sample(16'h0000, 16'h0000);
      check_flags(1'b0, 1'b0, 1'b0);
      repeat (10) @(posedge aclk);
      check_bit("alarm", 1'b0, alarm);
      // Interrupt raised by the masked-in event, cleared bit by bit
      check_bit("irq", 1'b1, irq);
      rd_check(limit_pkg::OFS_IRQ_STAT, 32'h0000_0003, 2'b00, "irq stat");
      axi_write(limit_pkg::OFS_IRQ_STAT, 32'h0000_0002, 2'b00);
      rd_check(limit_pkg::OFS_IRQ_STAT, 32'h0000_0001, 2'b00, "irq stat");
      check_bit("irq", 1'b0, irq);
      axi_write(limit_pkg::OFS_IRQ_STAT, 32'h0000_0001, 2'b00);
      // Held violation latches the alarm until acknowledged
      send_sample(16'h0190, 16'h0000);
      check_flags(1'b1, 1'b1, 1'b0);
      repeat (9) @(posedge aclk);
      check_bit("alarm", 1'b1, alarm);
      send_sample(16'h0000, 16'h0000);
      check_flags(1'b0, 1'b0, 1'b1);
      axi_write(limit_pkg::OFS_CTRL, 32'h0000_0100, 2'b00);
      repeat (2) @(posedge aclk);
      check_bit("alarm", 1'b0, alarm);
      // Dynamic limit: 100 * 2.0 + 300
      axi_write(limit_pkg::OFS_SCALE, 32'h0000_0200, 2'b00);
      axi_write(limit_pkg::OFS_CTRL, 32'h0000_0001, 2'b00);
      send_sample(16'h0000, 16'h0064);
      rd_check(limit_pkg::OFS_LIMIT, 32'h0000_01F4, 2'b00, "dyn limit");
      rd_check(limit_pkg::OFS_WARN_LIMIT, 32'h0000_0190, 2'b00, "dyn warn");
      send_sample(16'h01F5, 16'h0064);
      check_flags(1'b1, 1'b1, 1'b0);
      send_sample(16'h01F5, 16'h0065);
      check_flags(1'b1, 1'b0, 1'b0);
      send_sample(16'h0000, 16'h0000);
      // Stepwise limit with a lower offset on a higher step
      for (i = 0; i < 3; i++)
         axi_write(limit_pkg::OFS_STEP0 + 8'(4 * i), {ofs[i], thr[i]}, 2'b00);
      axi_write(limit_pkg::OFS_CTRL, 32'h0000_0032, 2'b00);
      for (i = 0; i < 5; i++)
      begin
         send_sample(16'h0000, refs[i]);
         rd_check(limit_pkg::OFS_LIMIT, lims[i], 2'b00, "step limit");
      end
      // Spare mode code falls back to the static limit despite configured steps
      axi_write(limit_pkg::OFS_CTRL, 32'h0000_0033, 2'b00);
      send_sample(16'h0000, 16'h015E);
      rd_check(limit_pkg::OFS_LIMIT, 32'h0000_012C, 2'b00, "mode3 limit");
      // Temperature from the average of eight resistance samples
      axi_write(limit_pkg::OFS_TEMP_CFG, 32'h0100_0064, 2'b00);
      for (i = 0; i < 8; i++)
      begin
         res_valid <= 1'b1;
         res_value <= i[0] ? 16'h0080 : 16'h0070;
         @(posedge aclk);
      end
      res_valid <= 1'b0;
      for (n = 0; n < 20 && temp_ready !== 1'b1; n++)
         @(posedge aclk);
      check_bit("temp ready", 1'b1, temp_ready);
      check_word("temperature", 32'h0000_0014, {16'h0000, temperature});
      rd_check(limit_pkg::OFS_TEMP, 32'h0000_0014, 2'b00, "temp reg");
      report_and_stop();
   end
endmodule : tb_top

`default_nettype wire
